// >>> design/spc_pkg.sv
package spc_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] SPC_A_CTRL = 8'h00;
  localparam logic [7:0] SPC_A_SEL = 8'h04;
  localparam logic [7:0] SPC_A_ACC = 8'h08;
  localparam logic [7:0] SPC_A_LIMIT = 8'h0C;
  localparam logic [7:0] SPC_A_OFFSET = 8'h10;
  localparam logic [7:0] SPC_A_CS = 8'h14;
  localparam logic [7:0] SPC_A_SS = 8'h18;
  localparam logic [7:0] SPC_A_DATA_SEG = 8'h1C;
  localparam logic [7:0] SPC_A_EXTRA_SEG = 8'h20;
  localparam logic [7:0] SPC_A_STATUS = 8'h24;
  localparam logic [7:0] SPC_A_RESULT = 8'h28;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] SPC_RST_SEG = 16'h0000;
  localparam logic [7:0] SPC_RST_ACC = 8'h00;
  localparam logic [3:0] SPC_RST_OP = 4'h0;

  // ----------------------------------------
  // Operation codes in CTRL[3:0]
  // ----------------------------------------
  localparam logic [3:0] SPC_OP_NONE = 4'h0;
  localparam logic [3:0] SPC_OP_LOAD_DATA = 4'h1;
  localparam logic [3:0] SPC_OP_LOAD_EXTRA = 4'h2;
  localparam logic [3:0] SPC_OP_LOAD_SS = 4'h3;
  localparam logic [3:0] SPC_OP_JMP_CALL = 4'h4;
  localparam logic [3:0] SPC_OP_RET = 4'h5;
  localparam logic [3:0] SPC_OP_READ = 4'h6;
  localparam logic [3:0] SPC_OP_WRITE = 4'h7;
  localparam logic [3:0] SPC_OP_EXEC = 4'h8;
  localparam logic [3:0] SPC_OP_PREFETCH = 4'h9;
  localparam logic [3:0] SPC_OP_VERIFY_RD = 4'hA;
  localparam logic [3:0] SPC_OP_VERIFY_WR = 4'hB;
  localparam logic [3:0] SPC_OP_LOAD_RIGHTS = 4'hC;
  localparam logic [3:0] SPC_OP_STAMP = 4'hD;

  // ----------------------------------------
  // Access byte and selector fields
  // ----------------------------------------
  localparam int SPC_ACC_RW = 1;
  localparam int SPC_ACC_CONF = 2;
  localparam int SPC_ACC_CODE = 3;
  localparam int SPC_ACC_SEG = 4;
  localparam int SPC_ACC_LVL_LO = 5;
  localparam int SPC_SEL_LVL_LO = 0;
  localparam logic [15:0] SPC_ERR_ZERO = 16'h0000;

  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int SPC_ST_BUSY = 0;
  localparam int SPC_ST_DONE = 1;
  localparam int SPC_ST_FAULT = 2;
  localparam int SPC_ST_OK = 3;
  localparam int SPC_ST_ERR_LO = 16;

  typedef enum logic [2:0] {
    SPC_IDLE = 3'b001,
    SPC_EVAL = 3'b010,
    SPC_COMMIT = 3'b100
  } spc_state_t;
endpackage

// >>> design/spc_segment_privilege_checker.sv
// Function
// - No data access to execute-only code: no data register load, no override read.
// - Executable segment goes into a data register only when readable bit is set.
// - Reading execute-only code faults with error code zero.
// - Loading a code segment into SS faults.
// - Code segments are never writable; a write faults with error code zero.
// - Code limit is last valid byte; offset above limit faults.
// - Prefetch past limit never faults; only execution beyond the end faults.
// - Readable non-conforming code into a data register uses data segment privilege checks.
// - Direct jump or call to non-conforming code needs current level equal descriptor level.
// - Return goes only to equal or numerically greater level.
// - More privileged non-conforming code reachable only through a call gate, never directly.
// - Conforming code target may have descriptor level below current level.
// - Current level lives in low bits of code and stack selectors only.
// - Descriptor level is access byte bits 5 and 6.
// - Data and non-conforming code access needs current level at most descriptor level.
// - Privilege violation on segment load faults with the selector, its two low bits cleared, as error code.
// - Requested level is the two low bits of the loaded selector.
// - Effective level is max of current and requested; must not exceed descriptor.
// - Stamping raises selector requested level to max of it and operand level.
// - Privilege checks happen when the selector is loaded, not at later references.
// - Verify-readable, verify-writable and load-access-rights operations are provided.
// - Access byte bit 3 marks code when set, data when clear.
// - For code, bit 1 means readable and bit 2 means conforming.
// - Stack segment descriptor level must equal current level, else fault.
`timescale 1ns/100ps
module spc_segment_privilege_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic gp_fault,
  output logic [15:0] gp_err_code
);
  spc_pkg::spc_state_t st_q;
  logic [3:0] op_q;
  logic [15:0] sel_q, lim_q, off_q, cs_q, ss_q, data_segment_reg_q, extra_segment_reg_q;
  logic [7:0] acc_q;
  logic fault_q, ok_q, done_q, fault_d, ok_d, sel_err;
  logic [15:0] err_q, res_q, res_d;
  logic [1:0] current_priv_level, requested_priv_level;
  logic [1:0] descriptor_priv_level, effective_priv_level, stamp_lvl;
  logic is_seg, is_code, is_rw, is_conf, beyond, eff_lvl_bad;
  logic setup, wr_acc, idle, start, addr_ok;
  logic [31:0] rd_mux;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  assign current_priv_level = cs_q[1:0];
  assign requested_priv_level = sel_q[spc_pkg::SPC_SEL_LVL_LO +: 2];
  assign descriptor_priv_level = acc_q[spc_pkg::SPC_ACC_LVL_LO +: 2];
  assign effective_priv_level = (current_priv_level > requested_priv_level) ?
    current_priv_level : requested_priv_level;
  assign is_seg = acc_q[spc_pkg::SPC_ACC_SEG];
  assign is_code = acc_q[spc_pkg::SPC_ACC_CODE];
  assign is_rw = acc_q[spc_pkg::SPC_ACC_RW];
  assign is_conf = is_code & acc_q[spc_pkg::SPC_ACC_CONF];
  assign beyond = off_q > lim_q;
  assign eff_lvl_bad = effective_priv_level > descriptor_priv_level;
  assign stamp_lvl = (off_q[1:0] > requested_priv_level) ? off_q[1:0] : requested_priv_level;

  // ----------------------------------------
  // Check evaluation
  // ----------------------------------------
  always_comb begin
    fault_d = 1'b0;
    ok_d = 1'b0;
    sel_err = 1'b0;
    res_d = 16'h0000;
    case (op_q)
      spc_pkg::SPC_OP_LOAD_DATA, spc_pkg::SPC_OP_LOAD_EXTRA: begin
        sel_err = 1'b1;
        fault_d = !is_seg | (is_code & !is_rw) | (!is_conf & eff_lvl_bad);
      end
      spc_pkg::SPC_OP_LOAD_SS: begin
        sel_err = 1'b1;
        fault_d = !is_seg | is_code | !is_rw | (descriptor_priv_level != current_priv_level) |
          (requested_priv_level != current_priv_level);
      end
      spc_pkg::SPC_OP_JMP_CALL: begin
        sel_err = 1'b1;
        if (is_conf) begin
          fault_d = !is_seg | (descriptor_priv_level > current_priv_level);
        end else begin
          fault_d = !is_seg | !is_code | (descriptor_priv_level != current_priv_level);
        end
      end
      spc_pkg::SPC_OP_RET: begin
        sel_err = 1'b1;
        fault_d = !is_seg | !is_code | (requested_priv_level < current_priv_level) |
          (!is_conf & (descriptor_priv_level != requested_priv_level)) |
          (is_conf & (descriptor_priv_level > requested_priv_level));
      end
      spc_pkg::SPC_OP_READ: begin
        fault_d = (is_code & !is_rw) | beyond;
      end
      spc_pkg::SPC_OP_WRITE: begin
        fault_d = is_code | !is_rw | beyond;
      end
      spc_pkg::SPC_OP_EXEC: begin
        fault_d = beyond;
      end
      spc_pkg::SPC_OP_PREFETCH: begin
        ok_d = !beyond;
      end
      spc_pkg::SPC_OP_VERIFY_RD: begin
        ok_d = is_seg & (!is_code | is_rw) & (is_conf | !eff_lvl_bad);
      end
      spc_pkg::SPC_OP_VERIFY_WR: begin
        ok_d = is_seg & !is_code & is_rw & !eff_lvl_bad;
      end
      spc_pkg::SPC_OP_LOAD_RIGHTS: begin
        ok_d = is_seg & (is_conf | !eff_lvl_bad);
        res_d = ok_d ? {acc_q, 8'h00} : 16'h0000;
      end
      spc_pkg::SPC_OP_STAMP: begin
        ok_d = off_q[1:0] > requested_priv_level;
        res_d = {sel_q[15:2], stamp_lvl};
      end
      default: begin
        fault_d = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  assign setup = psel & !penable;
  assign wr_acc = psel & penable & pwrite;
  assign idle = st_q == spc_pkg::SPC_IDLE;
  assign start = wr_acc & idle & (paddr == spc_pkg::SPC_A_CTRL) & (pwdata[3:0] != spc_pkg::SPC_OP_NONE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= spc_pkg::SPC_IDLE;
    end else begin
      case (st_q)
        spc_pkg::SPC_IDLE: begin
          if (start) begin
            st_q <= spc_pkg::SPC_EVAL;
          end
        end
        spc_pkg::SPC_EVAL: begin
          st_q <= spc_pkg::SPC_COMMIT;
        end
        spc_pkg::SPC_COMMIT: begin
          st_q <= spc_pkg::SPC_IDLE;
        end
        default: begin
          st_q <= spc_pkg::SPC_IDLE;
        end
      endcase
    end
  end

  // Operands are frozen while an operation runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= spc_pkg::SPC_RST_OP;
      sel_q <= spc_pkg::SPC_RST_SEG;
      acc_q <= spc_pkg::SPC_RST_ACC;
      lim_q <= spc_pkg::SPC_RST_SEG;
      off_q <= spc_pkg::SPC_RST_SEG;
    end else if (wr_acc & idle) begin
      case (paddr)
        spc_pkg::SPC_A_CTRL: op_q <= pwdata[3:0];
        spc_pkg::SPC_A_SEL: sel_q <= pwdata[15:0];
        spc_pkg::SPC_A_ACC: acc_q <= pwdata[7:0];
        spc_pkg::SPC_A_LIMIT: lim_q <= pwdata[15:0];
        spc_pkg::SPC_A_OFFSET: off_q <= pwdata[15:0];
        default: op_q <= op_q;
      endcase
    end
  end

  // Results latch once checks are complete
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
      ok_q <= 1'b0;
      err_q <= spc_pkg::SPC_ERR_ZERO;
      res_q <= spc_pkg::SPC_RST_SEG;
      done_q <= 1'b0;
    end else if (start) begin
      done_q <= 1'b0;
    end else if (st_q == spc_pkg::SPC_EVAL) begin
      fault_q <= fault_d;
      ok_q <= ok_d;
      err_q <= (fault_d & sel_err) ? {sel_q[15:2], 2'b00} : spc_pkg::SPC_ERR_ZERO;
      res_q <= res_d;
    end else if (st_q == spc_pkg::SPC_COMMIT) begin
      done_q <= 1'b1;
    end
  end

  // Segment registers change after a clean check, or by direct register write while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q <= spc_pkg::SPC_RST_SEG;
      ss_q <= spc_pkg::SPC_RST_SEG;
      data_segment_reg_q <= spc_pkg::SPC_RST_SEG;
      extra_segment_reg_q <= spc_pkg::SPC_RST_SEG;
    end else if (st_q == spc_pkg::SPC_COMMIT && !fault_q) begin
      case (op_q)
        spc_pkg::SPC_OP_LOAD_DATA: data_segment_reg_q <= sel_q;
        spc_pkg::SPC_OP_LOAD_EXTRA: extra_segment_reg_q <= sel_q;
        spc_pkg::SPC_OP_LOAD_SS: ss_q <= sel_q;
        spc_pkg::SPC_OP_JMP_CALL: cs_q <= {sel_q[15:2], current_priv_level};
        spc_pkg::SPC_OP_RET: begin
          cs_q <= sel_q;
          ss_q <= {ss_q[15:2], requested_priv_level};
        end
        default: cs_q <= cs_q;
      endcase
    end else if (wr_acc & idle) begin
      case (paddr)
        spc_pkg::SPC_A_CS: cs_q <= pwdata[15:0];
        spc_pkg::SPC_A_SS: ss_q <= pwdata[15:0];
        spc_pkg::SPC_A_DATA_SEG: data_segment_reg_q <= pwdata[15:0];
        spc_pkg::SPC_A_EXTRA_SEG: extra_segment_reg_q <= pwdata[15:0];
        default: cs_q <= cs_q;
      endcase
    end
  end

  // ----------------------------------------
  // APB read path, data captured in setup
  // ----------------------------------------
  always_comb begin
    addr_ok = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      spc_pkg::SPC_A_CTRL: rd_mux = {28'h0000000, op_q};
      spc_pkg::SPC_A_SEL: rd_mux = {16'h0000, sel_q};
      spc_pkg::SPC_A_ACC: rd_mux = {24'h000000, acc_q};
      spc_pkg::SPC_A_LIMIT: rd_mux = {16'h0000, lim_q};
      spc_pkg::SPC_A_OFFSET: rd_mux = {16'h0000, off_q};
      spc_pkg::SPC_A_CS: rd_mux = {16'h0000, cs_q};
      spc_pkg::SPC_A_SS: rd_mux = {16'h0000, ss_q};
      spc_pkg::SPC_A_DATA_SEG: rd_mux = {16'h0000, data_segment_reg_q};
      spc_pkg::SPC_A_EXTRA_SEG: rd_mux = {16'h0000, extra_segment_reg_q};
      spc_pkg::SPC_A_STATUS: begin
        rd_mux[spc_pkg::SPC_ST_ERR_LO +: 16] = err_q;
        rd_mux[spc_pkg::SPC_ST_BUSY] = !idle;
        rd_mux[spc_pkg::SPC_ST_DONE] = done_q;
        rd_mux[spc_pkg::SPC_ST_FAULT] = fault_q;
        rd_mux[spc_pkg::SPC_ST_OK] = ok_q;
      end
      spc_pkg::SPC_A_RESULT: rd_mux = {16'h0000, res_q};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= !addr_ok;
    end
  end

  assign pready = 1'b1;

  // ----------------------------------------
  // Fault report to the execution logic
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_fault <= 1'b0;
      gp_err_code <= spc_pkg::SPC_ERR_ZERO;
    end else begin
      gp_fault <= (st_q == spc_pkg::SPC_EVAL) & fault_d;
      if (st_q == spc_pkg::SPC_EVAL && fault_d) begin
        gp_err_code <= sel_err ? {sel_q[15:2], 2'b00} : spc_pkg::SPC_ERR_ZERO;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_EXEC_ONLY_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_EVAL && op_q == spc_pkg::SPC_OP_READ && is_code && !is_rw)
    |=> (fault_q && err_q == 16'h0000 && gp_fault))
    else $error("execute-only read did not fault with zero code");

  AST_DATA_EXEC_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_EVAL && op_q == spc_pkg::SPC_OP_LOAD_DATA && is_code && !is_rw)
    |=> fault_q ##1 (data_segment_reg_q == $past(data_segment_reg_q, 2)))
    else $error("execute-only segment reached data register");

  AST_SS_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_EVAL && op_q == spc_pkg::SPC_OP_LOAD_SS && is_code)
    |=> fault_q ##1 $stable(ss_q))
    else $error("code segment loaded into stack register");

  AST_CODE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_EVAL && op_q == spc_pkg::SPC_OP_WRITE && is_code)
    |=> (fault_q && gp_err_code == 16'h0000))
    else $error("write to code segment not refused");

  AST_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_EVAL && op_q == spc_pkg::SPC_OP_EXEC)
    |=> (fault_q == (off_q > lim_q)))
    else $error("code limit check wrong");

  AST_PREFETCH: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_EVAL && op_q == spc_pkg::SPC_OP_PREFETCH) |=> (!fault_q && !gp_fault))
    else $error("prefetch raised a fault");

  AST_JMP_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_EVAL && op_q == spc_pkg::SPC_OP_JMP_CALL && is_code && !is_conf &&
     descriptor_priv_level != current_priv_level) |=> fault_q ##1 $stable(cs_q))
    else $error("direct transfer across levels allowed");

  AST_EFF_LVL_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_EVAL && op_q == spc_pkg::SPC_OP_LOAD_EXTRA && is_seg && !is_code &&
     effective_priv_level > descriptor_priv_level)
    |=> (fault_q && err_q == {$past(sel_q[15:2]), 2'b00}))
    else $error("effective level violation not reported with selector");

  AST_STAMP: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_EVAL && op_q == spc_pkg::SPC_OP_STAMP)
    |=> (res_q[15:2] == sel_q[15:2] && res_q[1:0] >= sel_q[1:0] && res_q[1:0] >= off_q[1:0]
         && (res_q[1:0] == sel_q[1:0] || res_q[1:0] == off_q[1:0])))
    else $error("stamped selector wrong");

  AST_NO_COMMIT_ON_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_COMMIT && fault_q)
    |=> ($stable(cs_q) && $stable(ss_q) && $stable(data_segment_reg_q) && $stable(extra_segment_reg_q)
         && done_q))
    else $error("state changed after a fault");

  AST_GP_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    gp_fault |=> !gp_fault)
    else $error("fault pulse longer than one cycle");

  AST_SS_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_EVAL && op_q == spc_pkg::SPC_OP_LOAD_SS &&
     descriptor_priv_level != current_priv_level) |=> fault_q ##1 $stable(ss_q))
    else $error("stack load at a foreign level accepted");

  AST_RET_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_EVAL && op_q == spc_pkg::SPC_OP_RET &&
     requested_priv_level < current_priv_level) |=> fault_q ##1 $stable(cs_q))
    else $error("return to a more privileged level accepted");

  AST_CONF_JMP: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_EVAL && op_q == spc_pkg::SPC_OP_JMP_CALL && is_seg && is_conf &&
     descriptor_priv_level <= current_priv_level) |=> !fault_q)
    else $error("conforming target wrongly refused");

  AST_LOAD_PRIV: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_EVAL && op_q == spc_pkg::SPC_OP_LOAD_DATA && is_seg && !is_conf &&
     current_priv_level > descriptor_priv_level)
    |=> (fault_q && gp_err_code == {sel_q[15:2], 2'b00}))
    else $error("data load above the current level accepted");

  AST_CS_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == spc_pkg::SPC_COMMIT && !fault_q && op_q == spc_pkg::SPC_OP_JMP_CALL)
    |=> (cs_q[1:0] == $past(cs_q[1:0])))
    else $error("direct transfer changed the current level");
endmodule

// >>> tb/spc_cpu_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Processor side: segment loads and checks issued as register accesses
// ----------------------------------------
module spc_cpu_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // Request held from setup until pready is seen high, then released
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// >>> tb/segment_privilege_checker_test.sv
`timescale 1ns/100ps
module segment_privilege_checker_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, gp_fault, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] gp_err_code;
  int miscompares = 0;
  int n_tests = 0;
  int n_faults = 0;

  always #50 pclk = ~pclk;

  spc_segment_privilege_checker dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gp_fault(gp_fault), .gp_err_code(gp_err_code));
  spc_cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Fault pulses seen, one expected per failing operation
  always @(posedge pclk) begin
    if (gp_fault === 1'b1) n_faults <= n_faults + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic y;
    cpu.xfer(1'b1, a, d, x, y);
  endtask

  task automatic rd(input logic [7:0] a);
    cpu.xfer(1'b0, a, 32'h00000000, q, e);
  endtask

  function automatic logic [7:0] ab(input logic [1:0] lvl, input logic [2:0] t);
    return {1'b1, lvl, 1'b1, t, 1'b0};
  endfunction

  task automatic run(input logic [3:0] op, input logic [15:0] cs, input logic [15:0] sel, input logic [7:0] acc,
                     input logic [15:0] lim, input logic [15:0] off, input logic f, input logic ok,
                     input logic [15:0] err);
    int n0;
    int k;
    n0 = n_faults;
    wr(spc_pkg::SPC_A_CS, {16'h0000, cs});
    wr(spc_pkg::SPC_A_SEL, {16'h0000, sel});
    wr(spc_pkg::SPC_A_ACC, {24'h000000, acc});
    wr(spc_pkg::SPC_A_LIMIT, {16'h0000, lim});
    wr(spc_pkg::SPC_A_OFFSET, {16'h0000, off});
    wr(spc_pkg::SPC_A_CTRL, {28'h0000000, op});
    k = 0;
    q = 32'h00000000;
    while (q[spc_pkg::SPC_ST_DONE] !== 1'b1 && k < 20) begin
      rd(spc_pkg::SPC_A_STATUS);
      k++;
    end
    check(q[spc_pkg::SPC_ST_DONE], 1'b1, "done flag");
    check(q[spc_pkg::SPC_ST_FAULT], f, "fault flag");
    check(n_faults - n0, f, "fault pulses");
    if (f === 1'b1) begin
      check(q[31:16], err, "status error code");
      check(gp_err_code, err, "error code port");
    end else begin
      check(q[spc_pkg::SPC_ST_OK], ok, "ok flag");
    end
    $display("test op %0h sel %h done", op, sel);
  endtask

  task automatic r(input logic [3:0] op, input logic [15:0] cs, input logic [15:0] sel, input logic [7:0] acc,
                   input logic f, input logic ok, input logic [15:0] err);
    run(op, cs, sel, acc, 16'h00FF, 16'h0010, f, ok, err);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    miscompares++;
    results();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(spc_pkg::SPC_A_STATUS);
    check(q, 32'h00000000, "status after reset");
    check({31'h0, e}, 32'h00000000, "mapped read no slave error");
    check({31'h0, pready}, 32'h00000001, "ready high");
    rd(spc_pkg::SPC_A_CS);
    check(q, 32'h00000000, "cs after reset");
    rd(8'h2C);
    check({31'h0, e}, 32'h00000001, "unmapped slave error");
    wr(spc_pkg::SPC_A_STATUS, 32'hFFFFFFFF);
    rd(spc_pkg::SPC_A_STATUS);
    check(q, 32'h00000000, "status is read only");
    wr(spc_pkg::SPC_A_SEL, 32'hFFFFFFFF);
    rd(spc_pkg::SPC_A_SEL);
    check(q, 32'h0000FFFF, "selector width");
    $display("test registers done");
    r(spc_pkg::SPC_OP_LOAD_DATA, 16'h0008, 16'h0010, ab(2'd3, 3'b100), 1'b1, 1'b0, 16'h0010);
    rd(spc_pkg::SPC_A_DATA_SEG);
    check(q, 32'h00000000, "data register kept on fault");
    r(spc_pkg::SPC_OP_LOAD_DATA, 16'h0008, 16'h0013, ab(2'd3, 3'b101), 1'b0, 1'b0, 16'h0000);
    rd(spc_pkg::SPC_A_DATA_SEG);
    check(q, 32'h00000013, "data register loaded");
    r(spc_pkg::SPC_OP_LOAD_DATA, 16'h000A, 16'h0010, ab(2'd1, 3'b101), 1'b1, 1'b0, 16'h0010);
    r(spc_pkg::SPC_OP_LOAD_EXTRA, 16'h000A, 16'h0020, ab(2'd1, 3'b001), 1'b1, 1'b0, 16'h0020);
    r(spc_pkg::SPC_OP_LOAD_EXTRA, 16'h000A, 16'h0023, ab(2'd2, 3'b001), 1'b1, 1'b0, 16'h0020);
    r(spc_pkg::SPC_OP_LOAD_EXTRA, 16'h000A, 16'h0023, ab(2'd3, 3'b000), 1'b0, 1'b0, 16'h0000);
    rd(spc_pkg::SPC_A_EXTRA_SEG);
    check(q, 32'h00000023, "extra register loaded");
    r(spc_pkg::SPC_OP_LOAD_SS, 16'h0008, 16'h0030, ab(2'd0, 3'b101), 1'b1, 1'b0, 16'h0030);
    r(spc_pkg::SPC_OP_LOAD_SS, 16'h000A, 16'h0032, ab(2'd2, 3'b001), 1'b0, 1'b0, 16'h0000);
    r(spc_pkg::SPC_OP_LOAD_SS, 16'h000A, 16'h0032, ab(2'd1, 3'b001), 1'b1, 1'b0, 16'h0030);
    wr(spc_pkg::SPC_A_DATA_SEG, 32'h00000003);
    r(spc_pkg::SPC_OP_LOAD_EXTRA, 16'h0008, 16'h0040, ab(2'd0, 3'b001), 1'b0, 1'b0, 16'h0000);
    rd(spc_pkg::SPC_A_EXTRA_SEG);
    check(q, 32'h00000040, "extra register loaded at level zero");
    r(spc_pkg::SPC_OP_READ, 16'h0008, 16'h0040, ab(2'd0, 3'b100), 1'b1, 1'b0, 16'h0000);
    run(spc_pkg::SPC_OP_READ, 16'h0008, 16'h0040, ab(2'd0, 3'b101), 16'h00FF, 16'h00FF, 1'b0, 1'b0, 16'h0000);
    r(spc_pkg::SPC_OP_WRITE, 16'h0008, 16'h0040, ab(2'd0, 3'b101), 1'b1, 1'b0, 16'h0000);
    run(spc_pkg::SPC_OP_EXEC, 16'h0008, 16'h0040, ab(2'd0, 3'b100), 16'h00FF, 16'h00FF, 1'b0, 1'b0, 16'h0000);
    run(spc_pkg::SPC_OP_EXEC, 16'h0008, 16'h0040, ab(2'd0, 3'b100), 16'h00FF, 16'h0100, 1'b1, 1'b0, 16'h0000);
    run(spc_pkg::SPC_OP_PREFETCH, 16'h0008, 16'h0040, ab(2'd0, 3'b100),
      16'h00FF, 16'h0100, 1'b0, 1'b0, 16'h0000);
    r(spc_pkg::SPC_OP_JMP_CALL, 16'h000A, 16'h0050, ab(2'd2, 3'b100), 1'b0, 1'b0, 16'h0000);
    rd(spc_pkg::SPC_A_CS);
    check(q, 32'h00000052, "cs after direct jump");
    r(spc_pkg::SPC_OP_JMP_CALL, 16'h000A, 16'h0050, ab(2'd0, 3'b100), 1'b1, 1'b0, 16'h0050);
    r(spc_pkg::SPC_OP_JMP_CALL, 16'h000A, 16'h0050, ab(2'd0, 3'b111), 1'b0, 1'b0, 16'h0000);
    r(spc_pkg::SPC_OP_RET, 16'h000A, 16'h0053, ab(2'd3, 3'b100), 1'b0, 1'b0, 16'h0000);
    rd(spc_pkg::SPC_A_CS);
    check(q, 32'h00000053, "cs after return");
    rd(spc_pkg::SPC_A_SS);
    check(q, 32'h00000033, "stack level after return");
    r(spc_pkg::SPC_OP_RET, 16'h000A, 16'h0051, ab(2'd1, 3'b100), 1'b1, 1'b0, 16'h0050);
    r(spc_pkg::SPC_OP_VERIFY_RD, 16'h0008, 16'h0060, ab(2'd3, 3'b001), 1'b0, 1'b1, 16'h0000);
    r(spc_pkg::SPC_OP_VERIFY_RD, 16'h0008, 16'h0060, ab(2'd3, 3'b100), 1'b0, 1'b0, 16'h0000);
    r(spc_pkg::SPC_OP_VERIFY_WR, 16'h0008, 16'h0060, ab(2'd3, 3'b001), 1'b0, 1'b1, 16'h0000);
    r(spc_pkg::SPC_OP_VERIFY_WR, 16'h0008, 16'h0060, ab(2'd3, 3'b000), 1'b0, 1'b0, 16'h0000);
    r(spc_pkg::SPC_OP_LOAD_RIGHTS, 16'h0008, 16'h0060, ab(2'd3, 3'b001), 1'b0, 1'b1, 16'h0000);
    rd(spc_pkg::SPC_A_RESULT);
    check(q, {16'h0000, ab(2'd3, 3'b001), 8'h00}, "access rights result");
    run(spc_pkg::SPC_OP_STAMP, 16'h0008, 16'h0041, 8'h00, 16'h00FF, 16'h0003, 1'b0, 1'b1, 16'h0000);
    rd(spc_pkg::SPC_A_RESULT);
    check(q, 32'h00000043, "stamp raised");
    run(spc_pkg::SPC_OP_STAMP, 16'h0008, 16'h0043, 8'h00, 16'h00FF, 16'h0001, 1'b0, 1'b0, 16'h0000);
    rd(spc_pkg::SPC_A_RESULT);
    check(q, 32'h00000043, "stamp unchanged");
    results();
  end
endmodule
